// ===== hdl/tie_map.svh
// register offsets, field positions, reset values and masks of the block
`ifndef TIE_MAP_SVH
`define TIE_MAP_SVH

// ============================================================
// address map (byte addresses, one aligned word each)
`define TIE_CH_STRIDE      8'h10
`define TIE_OFS_ENABLE     4'h0
`define TIE_OFS_STATUS     4'h4
`define TIE_OFS_IRQ_STAT   8'h30
`define TIE_OFS_IRQ_MASK   8'h34

// ============================================================
// enable register fields
`define TIE_BIT_ADC_TRIG   7
`define TIE_BIT_RSVD_ONE   6
`define TIE_BIT_UNDERFLOW  5
`define TIE_BIT_OVERFLOW   4
`define TIE_BIT_GR_D       3
`define TIE_BIT_GR_C       2
`define TIE_BIT_GR_B       1
`define TIE_BIT_GR_A       0
`define TIE_EN_RESET       8'h00
`define TIE_EN_READ_ONES   8'h40
`define TIE_EN_WMASK_CH0   8'h9f
`define TIE_EN_WMASK_CHX   8'hb3

// ============================================================
// status register fields
`define TIE_BIT_DIR        7
`define TIE_ST_RESET       8'h00
`define TIE_ST_FMASK_CH0   8'h1f
`define TIE_ST_FMASK_CHX   8'h33

// ============================================================
// summary interrupt registers
`define TIE_IRQ_W          6
`define TIE_IRQ_RESET      6'h00
`define TIE_IRQ_ADC_LSB    0
`define TIE_IRQ_FLAG_LSB   3

`endif

// ===== hdl/tie_pkg.sv
// types shared by the timer interrupt enable block
package tie_pkg;

  // ============================================================
  // register select decoded from a bus address
  typedef enum logic [4:0] {
    TIE_SEL_NONE = 5'b00001,
    TIE_SEL_EN   = 5'b00010,
    TIE_SEL_ST   = 5'b00100,
    TIE_SEL_IST  = 5'b01000,
    TIE_SEL_IMSK = 5'b10000
  } tie_sel_t;

  typedef logic [7:0] tie_byte_t;

endpackage : tie_pkg

// ===== hdl/tie_chan.sv
// one timer channel: enable register, status flags and request gating
`timescale 1ns/1ps
`include "tie_map.svh"

module tie_chan #(
  parameter bit IS_CH0 = 1'b0,
  parameter int CW     = 16
) (
  // clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // counter side
  input  wire logic [CW-1:0]   channel_counter,
  input  wire logic            count_up,
  input  wire logic            phase_mode,
  input  wire logic [3:0]      match_event,
  // register access strobes
  input  wire logic            en_we,
  input  wire logic            st_we,
  input  wire logic            st_re,
  input  wire tie_pkg::tie_byte_t wdata,
  output tie_pkg::tie_byte_t   en_rd,
  output tie_pkg::tie_byte_t   st_rd,
  // requests
  output logic                 overflow_irq_req,
  output logic                 underflow_irq_req,
  output logic [3:0]           gr_irq_req,
  output logic                 adc_start_req,
  output logic                 flag_set
);
  import tie_pkg::*;

  localparam tie_byte_t EN_WM = IS_CH0 ? `TIE_EN_WMASK_CH0
                                       : `TIE_EN_WMASK_CHX;
  localparam tie_byte_t FM    = IS_CH0 ? `TIE_ST_FMASK_CH0
                                       : `TIE_ST_FMASK_CHX;

  tie_byte_t   en_q, en_d, flag_q, flag_d, seen_q, seen_d;
  logic [CW-1:0] prev_q;
  logic        vld_q, adc_q, fset_q;
  logic        ovf_hit, udf_hit, dir_bit;
  tie_byte_t   set_w, clr_w;

  // ============================================================
  // wrap detection against the previous counter sample
  assign ovf_hit = vld_q && (prev_q == '1) && (channel_counter == '0);
  // channel 0 has no phase counting, so no underflow
  assign udf_hit = !IS_CH0 && phase_mode && vld_q &&
                   (prev_q == '0) && (channel_counter == '1);

  // ============================================================
  // flags: set wins over a clear in the same cycle
  assign set_w  = {2'b00, udf_hit, ovf_hit, match_event} & FM;
  // only a 0 written to a flag first read as 1 clears it
  assign clr_w  = {8{st_we}} & seen_q & ~wdata & FM;
  assign flag_d = set_w | (flag_q & ~clr_w);
  assign seen_d = st_re ? flag_q : (seen_q & ~clr_w);
  // unwritable positions never take a one
  assign en_d   = en_we ? (wdata & EN_WM) : en_q;

  // ============================================================
  // read views
  assign dir_bit = IS_CH0 ? 1'b1 : count_up;
  assign en_rd   = en_q | `TIE_EN_READ_ONES;
  assign st_rd   = {dir_bit, 1'b1, flag_q[5:0]};

  // ============================================================
  // request levels: flag and enable, both flops; adc start and flag_set each come straight from one flop
  assign overflow_irq_req  = flag_q[`TIE_BIT_OVERFLOW] &
                             en_q[`TIE_BIT_OVERFLOW];
  assign underflow_irq_req = flag_q[`TIE_BIT_UNDERFLOW] &
                             en_q[`TIE_BIT_UNDERFLOW];
  assign gr_irq_req        = flag_q[3:0] & en_q[3:0];
  assign adc_start_req     = adc_q;
  assign flag_set          = fset_q;

  // registers of this channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q   <= `TIE_EN_RESET;
      flag_q <= `TIE_ST_RESET;
      seen_q <= `TIE_ST_RESET;
      prev_q <= '0;
      vld_q  <= 1'b0;
      adc_q  <= 1'b0;
      fset_q <= 1'b0;
    end else begin
      en_q   <= en_d;
      flag_q <= flag_d;
      seen_q <= seen_d;
      prev_q <= channel_counter;
      vld_q  <= 1'b1;
      adc_q  <= match_event[`TIE_BIT_GR_A] & en_q[`TIE_BIT_ADC_TRIG];
      fset_q <= |(set_w & ~flag_q);
    end
  end

endmodule : tie_chan

// ===== hdl/tie_top.sv
// timer interrupt enable bank with an ahb-lite register slave
// ============================================================
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "tie_map.svh"

module tie_top #(
  parameter int NCH = 3,
  parameter int CW  = 16
) (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // timer channel state
  input  wire logic [NCH-1:0][CW-1:0] channel_counter,
  input  wire logic [NCH-1:0]         count_up,
  input  wire logic [NCH-1:0]         phase_mode,
  input  wire logic [NCH-1:0][3:0]    gr_match_event,
  // requests toward interrupt controller and converter
  output logic [NCH-1:0]              overflow_irq_req,
  output logic [NCH-1:0]              underflow_irq_req,
  output logic [NCH-1:0]              gr_a_irq_req,
  output logic [NCH-1:0]              gr_b_irq_req,
  output logic [NCH-1:0]              gr_c_irq_req,
  output logic [NCH-1:0]              gr_d_irq_req,
  output logic [NCH-1:0]              adc_start_req,
  output logic                        irq
);
  import tie_pkg::*;

  // ============================================================
  // elaboration check: summary registers leave room for 3 channels
  if (NCH < 1 || NCH > 3 || CW < 2) begin : g_bad_param
    $error("tie_top: NCH must be 1..3 and CW at least 2");
  end

  // decode a byte address into a register select
  function automatic tie_sel_t sel_of(input logic [31:0] a);
    logic [1:0] ch;
    ch = a[5:4];
    if (a[31:8] != 24'h0)
      sel_of = TIE_SEL_NONE;
    else if (a[7:0] == `TIE_OFS_IRQ_STAT)
      sel_of = TIE_SEL_IST;
    else if (a[7:0] == `TIE_OFS_IRQ_MASK)
      sel_of = TIE_SEL_IMSK;
    else if (a[7:6] != 2'b00 || int'(ch) >= NCH)
      sel_of = TIE_SEL_NONE;
    else if (a[3:0] == `TIE_OFS_ENABLE)
      sel_of = TIE_SEL_EN;
    else if (a[3:0] == `TIE_OFS_STATUS)
      sel_of = TIE_SEL_ST;
    else
      sel_of = TIE_SEL_NONE;
  endfunction : sel_of

  tie_sel_t              sel_a, sel_q;
  logic [1:0]            ch_a, ch_q;
  logic                  acc_w, rd_acc, wr_q;
  logic [31:0]           hrdata_q, rd_word;
  tie_byte_t             en_rd  [NCH];
  tie_byte_t             st_rd  [NCH];
  logic [NCH-1:0]        en_we, st_we, st_re, fset;
  logic [NCH-1:0][3:0]   gr_req;
  logic [`TIE_IRQ_W-1:0] ist_q, ist_d, imsk_q, imsk_d, ist_set;
  logic                  ist_we, imsk_we;

  // ============================================================
  // address phase: zero wait states, so hreadyout stays high
  assign acc_w     = hsel && htrans[1] && hready;
  assign rd_acc    = acc_w && !hwrite;
  assign sel_a     = sel_of(haddr);
  assign ch_a      = haddr[5:4];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // read mux, unmapped addresses read as zero
  assign rd_word =
    (sel_a == TIE_SEL_EN)   ? {24'h0, en_rd[ch_a]} :
    (sel_a == TIE_SEL_ST)   ? {24'h0, st_rd[ch_a]} :
    (sel_a == TIE_SEL_IST)  ? {26'h0, ist_q} :
    (sel_a == TIE_SEL_IMSK) ? {26'h0, imsk_q} : 32'h0;

  // address phase capture; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q     <= 1'b0;
      sel_q    <= TIE_SEL_NONE;
      ch_q     <= 2'h0;
      hrdata_q <= 32'h0;
    end else begin
      wr_q  <= acc_w && hwrite;
      sel_q <= sel_a;
      ch_q  <= ch_a;
      if (rd_acc)
        hrdata_q <= rd_word;
    end
  end

  // ============================================================
  // channels, each with its own enable register
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign en_we[i] = wr_q && sel_q == TIE_SEL_EN && int'(ch_q) == i;
    assign st_we[i] = wr_q && sel_q == TIE_SEL_ST && int'(ch_q) == i;
    assign st_re[i] = rd_acc && sel_a == TIE_SEL_ST && int'(ch_a) == i;
    assign gr_a_irq_req[i] = gr_req[i][`TIE_BIT_GR_A];
    assign gr_b_irq_req[i] = gr_req[i][`TIE_BIT_GR_B];
    assign gr_c_irq_req[i] = gr_req[i][`TIE_BIT_GR_C];
    assign gr_d_irq_req[i] = gr_req[i][`TIE_BIT_GR_D];

    tie_chan #(
      .IS_CH0 (i == 0),
      .CW     (CW)
    ) u_chan (
      .hclk              (hclk),
      .hresetn           (hresetn),
      .channel_counter   (channel_counter[i]),
      .count_up          (count_up[i]),
      .phase_mode        (phase_mode[i]),
      .match_event       (gr_match_event[i]),
      .en_we             (en_we[i]),
      .st_we             (st_we[i]),
      .st_re             (st_re[i]),
      .wdata             (hwdata[7:0]),
      .en_rd             (en_rd[i]),
      .st_rd             (st_rd[i]),
      .overflow_irq_req  (overflow_irq_req[i]),
      .underflow_irq_req (underflow_irq_req[i]),
      .gr_irq_req        (gr_req[i]),
      .adc_start_req     (adc_start_req[i]),
      .flag_set          (fset[i])
    );
  end

  // ============================================================
  // summary interrupt: sticky events, write one to clear
  always_comb begin
    ist_set = '0;
    ist_set[`TIE_IRQ_ADC_LSB +: NCH]  = adc_start_req;
    ist_set[`TIE_IRQ_FLAG_LSB +: NCH] = fset;
  end
  assign ist_we  = wr_q && sel_q == TIE_SEL_IST;
  assign imsk_we = wr_q && sel_q == TIE_SEL_IMSK;
  // a new event beats a clear arriving in the same cycle
  assign ist_d   = ist_set |
                   (ist_q & ~(ist_we ? hwdata[`TIE_IRQ_W-1:0] : '0));
  assign imsk_d  = imsk_we ? hwdata[`TIE_IRQ_W-1:0] : imsk_q;
  assign irq     = |(ist_q & imsk_q);

  // summary registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_q  <= `TIE_IRQ_RESET;
      imsk_q <= `TIE_IRQ_RESET;
    end else begin
      ist_q  <= ist_d;
      imsk_q <= imsk_d;
    end
  end

  // ============================================================
  // checks on all three channels (default three-channel build)
  if (NCH == 3) begin : g_chk
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_gra_hit;
      gr_match_event[1][0] && en_rd[1][7];
    endsequence
    sequence s_gra_miss;
      gr_match_event[2][0] && !en_rd[2][7];
    endsequence
    sequence s_wrap_up;
      channel_counter[0] == '1 ##1 channel_counter[0] == '0;
    endsequence
    sequence s_wrap_down;
      phase_mode[1] && channel_counter[1] == '0
      ##1 phase_mode[1] && channel_counter[1] == '1;
    endsequence
    sequence s_wrap_idle;
      !phase_mode[2] && channel_counter[2] == '0
      ##1 !phase_mode[2] && channel_counter[2] == '1;
    endsequence

    adc_trig_on_a: assert property (
      s_gra_hit |=> adc_start_req[1])
      else $error("adc start missing after enabled gr A match");
    adc_trig_off_a: assert property (
      s_gra_miss |=> !adc_start_req[2])
      else $error("adc start issued while disabled");
    rsvd_one_a: assert property (
      en_rd[0][6] && en_rd[1][6] && en_rd[2][6])
      else $error("enable bit 6 not reading 1");
    udf_gate_a: assert property (
      underflow_irq_req[1] == (st_rd[1][5] && en_rd[1][5]))
      else $error("underflow request not flag and enable");
    ch0_udf_a: assert property (
      !en_rd[0][5] && !underflow_irq_req[0] && !st_rd[0][5])
      else $error("channel 0 underflow bit not zero");
    ovf_gate_a: assert property (
      overflow_irq_req[2] == (st_rd[2][4] && en_rd[2][4]))
      else $error("overflow request not flag and enable");
    grd_gate_a: assert property (
      gr_d_irq_req[0] == (st_rd[0][3] && en_rd[0][3]))
      else $error("gr D request not flag and enable");
    rsvd_cd_a: assert property (
      en_rd[1][3:2] == 2'b00 && en_rd[2][3:2] == 2'b00)
      else $error("channel 1/2 bits 3..2 not zero");
    grc_gate_a: assert property (
      $rose(gr_c_irq_req[0]) |-> en_rd[0][2] && st_rd[0][2])
      else $error("gr C request without flag and enable");
    nocd_req_a: assert property (
      !gr_c_irq_req[1] && !gr_d_irq_req[2])
      else $error("gr C/D request on channel 1/2");
    grb_gate_a: assert property (
      gr_b_irq_req[1] == (st_rd[1][1] && en_rd[1][1]))
      else $error("gr B request not flag and enable");
    gra_gate_a: assert property (
      gr_a_irq_req[0] == (st_rd[0][0] && en_rd[0][0]))
      else $error("gr A request not flag and enable");
    en_indep_a: assert property (
      en_we[0] |=> $stable(en_rd[1]) && $stable(en_rd[2]))
      else $error("write to channel 0 changed another channel");
    ovf_wrap_a: assert property (
      s_wrap_up |=> st_rd[0][4])
      else $error("overflow flag not set after wrap");
    udf_wrap_a: assert property (
      s_wrap_down |=> st_rd[1][5])
      else $error("underflow flag not set after wrap");
    flag_clr_a: assert property (
      $fell(st_rd[2][4]) |-> $past(st_we[2]) && !$past(hwdata[4]))
      else $error("flag cleared without a zero write");
    req_level_a: assert property (
      st_rd[2][0] && en_rd[2][0] [*3] |-> gr_a_irq_req[2])
      else $error("request not held while flag and enable hold");

    // further channel checks, bus answer, write masks and summary interrupt
    adc_trig_ch0_a: assert property (
      gr_match_event[0][0] && en_rd[0][7] |=> adc_start_req[0])
      else $error("channel 0 adc start missing");
    en_indep1_a: assert property (
      en_we[1] |=> $stable(en_rd[0]) && $stable(en_rd[2]))
      else $error("write to channel 1 changed another channel");
    wmask_ch0_a: assert property (
      en_we[0] |=> en_rd[0] == ((`TIE_EN_WMASK_CH0 & $past(hwdata[7:0]))
                                | `TIE_EN_READ_ONES))
      else $error("channel 0 enable write mask wrong");
    wmask_chx_a: assert property (
      en_we[1] |=> en_rd[1] == ((`TIE_EN_WMASK_CHX & $past(hwdata[7:0]))
                                | `TIE_EN_READ_ONES))
      else $error("channel 1 enable write mask wrong");
    en_read_a: assert property (
      rd_acc && sel_a == TIE_SEL_EN |=> hrdata[31:8] == 24'h0 && hrdata[6])
      else $error("enable read word malformed");
    udf_off_a: assert property (
      !st_rd[2][5] ##0 s_wrap_idle |=> !st_rd[2][5])
      else $error("underflow flagged outside phase counting");
    bus_okay_a: assert property (
      hreadyout && !hresp)
      else $error("bus answer not ready and okay");
    ist_sticky_a: assert property (
      (|ist_set) |=> (ist_q & $past(ist_set)) == $past(ist_set))
      else $error("summary event lost");
    ist_w1c_a: assert property (
      ist_we && ist_set == '0
      |=> (ist_q & $past(hwdata[`TIE_IRQ_W-1:0])) == '0)
      else $error("summary bit not cleared by a one");
    irq_mask_a: assert property (
      imsk_q == '0 |-> !irq)
      else $error("interrupt raised with all events masked");
    ch0_dir_a: assert property (
      st_rd[0][7:6] == 2'b11)
      else $error("channel 0 status bits 7..6 not one");
    dir_view_a: assert property (
      st_rd[2][7] == count_up[2] && st_rd[2][6])
      else $error("channel 2 direction bit wrong");
  end

endmodule : tie_top

// ===== testbench/tie_far_model.sv
// far-side stand-in: timer counters that wrap on command, adc pulse counter
`timescale 1ns/1ps

module tie_far_model (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // wrap commands from the bench
  input  wire logic [2:0]       ovf_kick,
  input  wire logic [2:0]       unf_kick,
  // converter trigger input
  input  wire logic [2:0]       adc_start_req,
  // counter values and pulse tallies
  output logic [2:0][15:0]      channel_counter,
  output logic [2:0][7:0]       adc_cnt
);
  logic [2:0][15:0] nxt_q;

  // ============================================================
  // counters
  // a kick loads the value before the wrap and queues the wrap itself;
  // the counter then parks at a mid value so no stray wrap appears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_counter <= {3{16'h1234}};
      nxt_q           <= {3{16'h1234}};
      adc_cnt         <= '0;
    end else begin
      for (int n = 0; n < 3; n++) begin
        if (ovf_kick[n]) begin
          channel_counter[n] <= 16'hffff;
          nxt_q[n]           <= 16'h0000;
        end else if (unf_kick[n]) begin
          channel_counter[n] <= 16'h0000;
          nxt_q[n]           <= 16'hffff;
        end else begin
          channel_counter[n] <= nxt_q[n];
          nxt_q[n]           <= 16'h1234;
        end
        // each pulse is one conversion start, tallied for the bench
        if (adc_start_req[n]) begin
          adc_cnt[n] <= adc_cnt[n] + 8'h01;
        end
      end
    end
  end
endmodule : tie_far_model

// ===== testbench/tb.sv
// self-checking bench for the timer interrupt enable block
`timescale 1ns/1ps
`include "tie_map.svh"

module tb;
  logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       htrans;
  logic [2:0]       hsize, count_up, phase_mode, ovf_kick, unf_kick;
  logic [2:0][3:0]  gr_ev;
  logic [2:0][15:0] cnt;
  logic [2:0][7:0]  adc_cnt;
  logic [2:0]       ovf_r, unf_r, a_r, b_r, c_r, d_r, adc_r;
  int               error_cnt, n_checks;

  // ============================================================
  // design, far side and clock
  tie_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .channel_counter(cnt),
    .count_up(count_up), .phase_mode(phase_mode),
    .gr_match_event(gr_ev), .overflow_irq_req(ovf_r),
    .underflow_irq_req(unf_r), .gr_a_irq_req(a_r), .gr_b_irq_req(b_r),
    .gr_c_irq_req(c_r), .gr_d_irq_req(d_r), .adc_start_req(adc_r),
    .irq(irq));
  tie_far_model far (.hclk(hclk), .hresetn(hresetn), .ovf_kick(ovf_kick),
    .unf_kick(unf_kick), .adc_start_req(adc_r), .channel_counter(cnt),
    .adc_cnt(adc_cnt));

  initial hclk = 1'b0;
  always #10 hclk = ~hclk;

  // ============================================================
  // helpers
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one single ahb transfer; the leading edge leaves an idle cycle, so a
  // read after a write always sees the new value
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
    #1;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // match pulses and overflow in one cycle, underflow in the next
  task automatic fire(input int n, input logic [3:0] ev, input logic o,
                      input logic u);
    @(posedge hclk); gr_ev[n] <= ev; ovf_kick[n] <= o;
    @(posedge hclk); gr_ev[n] <= 4'h0; ovf_kick[n] <= 1'b0;
    unf_kick[n] <= u;
    @(posedge hclk); unf_kick[n] <= 1'b0;
    repeat (4) @(posedge hclk);
    #1;
  endtask : fire

  function automatic logic [31:0] req_of(input int n);
    return {26'h0, unf_r[n], ovf_r[n], d_r[n], c_r[n], b_r[n], a_r[n]};
  endfunction : req_of

  // flags that exist on a channel: ch0 lacks underflow, others lack c/d
  function automatic logic [31:0] vmask(input int n);
    return (n == 0) ? 32'h1f : 32'h33;
  endfunction : vmask

  function automatic logic [31:0] st_exp(input int n, input logic [31:0] f);
    return 32'h40 | f | ((n == 0 || count_up[n]) ? 32'h80 : 32'h0);
  endfunction : st_exp

  // ============================================================
  // watchdog: the sequence needs about two hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    wrap_up();
  end

  // ============================================================
  // main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = '0; count_up = 3'b010;
    phase_mode = 3'b110; ovf_kick = '0; unf_kick = '0; gr_ev = '0;
    error_cnt = 0; n_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and writable bits of each enable register
    for (int n = 0; n < 3; n++) begin
      rdchk(n * 16, 32'h40);
      wr(n * 16, 32'hff);
      rdchk(n * 16, (n == 0) ? 32'hdf : 32'hf3);
      wr(n * 16, 32'h0);
      rdchk(n * 16, 32'h40);
    end
    chk({31'h0, irq}, 32'h0);
    // unmapped word reads zero and ignores writes
    wr(32'h20 + 32'h8, 32'hff);
    rdchk(32'h20 + 32'h8, 32'h0);
    // all enables on, then events one channel at a time
    for (int n = 0; n < 3; n++) wr(n * 16, 32'hff);
    for (int n = 0; n < 3; n++) begin
      fire(n, 4'hf, 1'b1, 1'b1);
      for (int m = 0; m < 3; m++)
        chk(req_of(m), (m <= n) ? vmask(m) : 32'h0);
      rdchk(n * 16 + 4, st_exp(n, vmask(n)));
      chk({24'h0, adc_cnt[n]}, 32'h1);
    end
    // summary status, mask and interrupt line
    rdchk({24'h0, `TIE_OFS_IRQ_STAT}, 32'h3f);
    wr({24'h0, `TIE_OFS_IRQ_MASK}, 32'h08);
    chk({31'h0, irq}, 32'h1);
    wr({24'h0, `TIE_OFS_IRQ_STAT}, 32'h08);
    chk({31'h0, irq}, 32'h0);
    rdchk({24'h0, `TIE_OFS_IRQ_STAT}, 32'h37);
    wr({24'h0, `TIE_OFS_IRQ_MASK}, 32'h0);
    wr({24'h0, `TIE_OFS_IRQ_STAT}, 32'h3f);
    // one enable bit at a time gates exactly its own request
    for (int n = 0; n < 2; n++)
      for (int b = 0; b < 6; b++) begin
        wr(n * 16, 32'h1 << b);
        chk(req_of(n), (32'h1 << b) & vmask(n));
      end
    // adc trigger off: a gr a match starts no conversion
    wr(32'h20, 32'h7f);
    fire(2, 4'h1, 1'b0, 1'b0);
    chk({24'h0, adc_cnt[2]}, 32'h1);
    // clearing needs a prior read of the flag as one
    rdchk(32'h24, st_exp(2, 32'h33));
    wr(32'h24, 32'h0);
    rdchk(32'h24, 32'h40);
    chk(req_of(2), 32'h0);
    fire(2, 4'h1, 1'b0, 1'b0);
    wr(32'h24, 32'h0);
    rdchk(32'h24, 32'h41);
    wr(32'h24, 32'h01);
    rdchk(32'h24, 32'h41);
    wr(32'h24, 32'h0);
    rdchk(32'h24, 32'h40);
    // outside phase counting mode no underflow is flagged
    @(posedge hclk);
    phase_mode[2] <= 1'b0;
    fire(2, 4'h0, 1'b0, 1'b1);
    rdchk(32'h24, 32'h40);
    wrap_up();
  end
endmodule : tb
